// *** rtl/feedback_pkg.sv ***
// Package with offsets, widths, reset values and carrier types of the block.
package feedback_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int HALF_W = 16;
    localparam int NUM_REGS = 6;

    // Register offsets on the serial register interface.
    localparam logic [11:0] OFF_SENSE_GAIN = 12'h468;
    localparam logic [11:0] OFF_VOLT_RANGE = 12'h472;
    localparam logic [11:0] OFF_SUPPLY = 12'h474;
    localparam logic [11:0] OFF_PHASE_A = 12'h47a;
    localparam logic [11:0] OFF_PHASE_B = 12'h47c;
    localparam logic [11:0] OFF_PHASE_C = 12'h47e;

    // Reset values.
    localparam logic [15:0] RST_HALF = 16'h0000;
    localparam logic [31:0] RST_WORD = 32'h00000000;

    // Sense-gain codes: multiple of the maximum amplifier gain.
    localparam logic [15:0] GAIN_X8 = 16'h0000;
    localparam logic [15:0] GAIN_X4 = 16'h0001;
    localparam logic [15:0] GAIN_X2 = 16'h0002;
    localparam logic [15:0] GAIN_X1 = 16'h0003;

    // Voltage-range codes: full scale of the voltage measurement.
    localparam logic [15:0] RANGE_60V = 16'h0000;
    localparam logic [15:0] RANGE_30V = 16'h0001;
    localparam logic [15:0] RANGE_15V = 16'h0002;

    // Fixed-point scaling: supply volts = value * 60 / 2^27; phase volts
    // additionally divide by root three.
    localparam int SCALE_VOLTS = 60;
    localparam int SCALE_SHIFT = 27;

    // Values produced by the control algorithm, with their update strobes.
    typedef struct packed {
        logic [15:0] sense_gain;
        logic [15:0] volt_range;
        logic [31:0] supply;
        logic [31:0] phase_a;
        logic [31:0] phase_b;
        logic [31:0] phase_c;
    } feedback_t;

    typedef struct packed {
        logic sense_gain;
        logic volt_range;
        logic supply;
        logic phase;
    } feedback_stb_t;

    // Register read or write request from the serial interface logic.
    typedef struct packed {
        logic rd;
        logic wr;
        logic [11:0] addr;
        logic [31:0] wdata;
    } reg_req_t;
endpackage

// *** rtl/feedback_hold.sv ***
`timescale 1ns/1ps
// Holding register for one feedback value, loaded only by the core.
module feedback_hold #(
    parameter int W = 32
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic load,
    input wire logic [W-1:0] value,
    output logic [W-1:0] held
);
    logic [W-1:0] held_q;
    logic [W-1:0] held_d;

    // Only the core strobe loads; no bus path exists into this register.
    always_comb begin
        held_d = load ? value : held_q;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            held_q <= '0;
        end else begin
            held_q <= held_d;
        end
    end

    assign held = held_q;
endmodule

// *** rtl/feedback_decode.sv ***
`timescale 1ns/1ps
// Address decoder mapping a register offset to a one-hot select.
module feedback_decode (
    input wire logic [11:0] addr,
    output logic [5:0] sel,
    output logic hit
);
    // Each mapped offset selects exactly one register; others miss.
    always_comb begin
        sel = 6'h00;
        case (addr)
            feedback_pkg::OFF_SENSE_GAIN: sel = 6'h01;
            feedback_pkg::OFF_VOLT_RANGE: sel = 6'h02;
            feedback_pkg::OFF_SUPPLY: sel = 6'h04;
            feedback_pkg::OFF_PHASE_A: sel = 6'h08;
            feedback_pkg::OFF_PHASE_B: sel = 6'h10;
            feedback_pkg::OFF_PHASE_C: sel = 6'h20;
            default: sel = 6'h00;
        endcase
        hit = |sel;
    end
endmodule

// *** rtl/motor_feedback_readback_regs.sv ***
`timescale 1ns/1ps
// Read-only feedback register bank of the motor controller.
//
// Overview of operation
// [R1] Sense gain readback: 16-bit, read-only, resets zero.
// [R2] Gain codes 0..3 mean 8x,4x,2x,1x maximum.
// [R3] Range readback 16-bit: codes 60V, 30V, 15V.
// [R4] Supply voltage 32-bit, volts = value*60/2^27.
// [R5] Phase A sample, 32-bit, scaled 60/(root3*2^27).
// [R6] Phase B sample, same scaling as phase A.
// [R7] Phase C sample, same scaling as phase A.
// [R8] Reads harmless; host writes ignored, values unchanged.
module motor_feedback_readback_regs (
    input wire logic clk,
    input wire logic reset,
    input wire feedback_pkg::feedback_t core_value,
    input wire feedback_pkg::feedback_stb_t core_load,
    input wire feedback_pkg::reg_req_t req,
    output logic [31:0] rdata,
    output logic rvalid,
    output logic rerr
);
    logic [15:0] sense_gain;
    logic [15:0] volt_range;
    logic [31:0] supply;
    logic [31:0] phase_a;
    logic [31:0] phase_b;
    logic [31:0] phase_c;
    logic [5:0] sel;
    logic hit;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic rvalid_q;
    logic rvalid_d;
    logic rerr_q;
    logic rerr_d;
    logic [15:0] gain_code;
    logic [15:0] range_code;

    // Codes outside the documented sets are held back so software never
    // sees an encoding it cannot interpret; the last legal code stays.
    always_comb begin
        case (core_value.sense_gain)
            feedback_pkg::GAIN_X8,
            feedback_pkg::GAIN_X4,
            feedback_pkg::GAIN_X2,
            feedback_pkg::GAIN_X1: gain_code = core_value.sense_gain; // R2
            default: gain_code = sense_gain;
        endcase
        case (core_value.volt_range)
            feedback_pkg::RANGE_60V,
            feedback_pkg::RANGE_30V,
            feedback_pkg::RANGE_15V: range_code = core_value.volt_range; // R3
            default: range_code = volt_range;
        endcase
    end

    // Holding registers; only the core strobes load them.
    feedback_hold #(.W(16)) u_gain (
        .clk(clk),
        .reset(reset),
        .load(core_load.sense_gain), // R1
        .value(gain_code),
        .held(sense_gain)
    );

    feedback_hold #(.W(16)) u_range (
        .clk(clk),
        .reset(reset),
        .load(core_load.volt_range), // R3
        .value(range_code),
        .held(volt_range)
    );

    feedback_hold #(.W(32)) u_supply (
        .clk(clk),
        .reset(reset),
        .load(core_load.supply), // R4
        .value(core_value.supply),
        .held(supply)
    );

    // The three phase samples load together so they stay coherent.
    feedback_hold #(.W(32)) u_pha (
        .clk(clk),
        .reset(reset),
        .load(core_load.phase), // R5
        .value(core_value.phase_a),
        .held(phase_a)
    );

    feedback_hold #(.W(32)) u_phb (
        .clk(clk),
        .reset(reset),
        .load(core_load.phase), // R6
        .value(core_value.phase_b),
        .held(phase_b)
    );

    feedback_hold #(.W(32)) u_phc (
        .clk(clk),
        .reset(reset),
        .load(core_load.phase), // R7
        .value(core_value.phase_c),
        .held(phase_c)
    );

    feedback_decode u_dec (
        .addr(req.addr),
        .sel(sel),
        .hit(hit)
    );

    // Read mux; 16-bit registers read zero in the upper half. Writes get
    // an acknowledge but never reach the holding registers.
    always_comb begin
        rdata_d = rdata_q;
        rvalid_d = 1'b0;
        rerr_d = 1'b0;
        if (req.rd) begin
            rvalid_d = 1'b1;
            rerr_d = ~hit;
            rdata_d = 32'h00000000;
            case (1'b1)
                sel[0]: rdata_d = {16'h0000, sense_gain}; // R1
                sel[1]: rdata_d = {16'h0000, volt_range}; // R3
                sel[2]: rdata_d = supply; // R4
                sel[3]: rdata_d = phase_a; // R5
                sel[4]: rdata_d = phase_b; // R6
                sel[5]: rdata_d = phase_c; // R7
                default: rdata_d = 32'h00000000;
            endcase
        end else if (req.wr) begin
            rvalid_d = 1'b1; // R8
            rerr_d = ~hit;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rdata_q <= 32'h00000000;
            rvalid_q <= 1'b0;
            rerr_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
            rerr_q <= rerr_d;
        end
    end

    assign rdata = rdata_q;
    assign rvalid = rvalid_q;
    assign rerr = rerr_q;

    // A write with no supply load leaves the supply readback unchanged.
    property p_write_ignored;
        @(posedge clk) disable iff (reset)
        (req.wr && !req.rd && !core_load.supply) |=> $stable(supply);
    endproperty
    AST_WRITE_IGNORED: assert property (p_write_ignored) // R8
        else $error("Host write changed supply readback.");

    AST_GAIN_RANGE: assert property ( // R2
        @(posedge clk) disable iff (reset) sense_gain <= 16'h0003)
        else $error("Sense gain code out of range.");

    AST_RANGE_CODES: assert property ( // R3
        @(posedge clk) disable iff (reset) volt_range <= 16'h0002)
        else $error("Voltage range code out of range.");

    sequence s_gain_rd;
        req.rd && sel[0];
    endsequence
    AST_GAIN_READ: assert property ( // R1
        @(posedge clk) disable iff (reset)
        s_gain_rd |=> rvalid && rdata == {16'h0000, $past(sense_gain)})
        else $error("Sense gain read data wrong.");

    AST_SUPPLY_LOAD: assert property ( // R4
        @(posedge clk) disable iff (reset)
        core_load.supply |=> supply == $past(core_value.supply))
        else $error("Supply readback not loaded.");

    sequence s_phase_load;
        core_load.phase;
    endsequence
    AST_PHASE_A: assert property ( // R5
        @(posedge clk) disable iff (reset)
        s_phase_load |=> phase_a == $past(core_value.phase_a))
        else $error("Phase A sample not loaded.");

    AST_PHASE_B: assert property ( // R6
        @(posedge clk) disable iff (reset)
        s_phase_load ##1 (req.rd && sel[4]) |=> rdata == $past(phase_b))
        else $error("Phase B read data wrong.");

    AST_PHASE_C: assert property ( // R7
        @(posedge clk) disable iff (reset)
        !core_load.phase |=> $stable(phase_c))
        else $error("Phase C sample changed without load.");

    AST_UNMAPPED: assert property ( // R8
        @(posedge clk) disable iff (reset)
        (req.rd && !hit) |=> rvalid && rerr && rdata == 32'h00000000)
        else $error("Unmapped read answered wrongly.");

    // Exactly one answer pulse per taken request, one cycle later; the
    // host relies on this to pair answers with calls when back to back.
    AST_ANSWER_PULSE: assert property ( // R8
        @(posedge clk) disable iff (reset)
        rvalid == $past(req.rd || req.wr))
        else $error("Answer pulse does not follow the request.");

    // An error flag never stands without its answer pulse.
    AST_RERR_VALID: assert property ( // R8
        @(posedge clk) disable iff (reset)
        rerr |-> rvalid)
        else $error("Error flag raised without an answer.");

    // Read data stands until the next read, so a write or an idle cycle
    // must not disturb what software last fetched.
    AST_RDATA_HOLD: assert property ( // R8
        @(posedge clk) disable iff (reset)
        !req.rd |=> $stable(rdata))
        else $error("Read data changed without a read.");

    // A write to a mapped offset is acknowledged without an error.
    AST_WRITE_ACK: assert property ( // R8
        @(posedge clk) disable iff (reset)
        (req.wr && !req.rd && hit) |=> rvalid && !rerr)
        else $error("Mapped write answered with an error.");

    // Range readback returns the code in the lower half.
    sequence s_range_rd;
        req.rd && sel[1];
    endsequence
    AST_RANGE_READ: assert property ( // R3
        @(posedge clk) disable iff (reset)
        s_range_rd |=> rdata == {16'h0000, $past(volt_range)})
        else $error("Voltage range read data wrong.");

    // Supply readback returns the whole word.
    sequence s_supply_rd;
        req.rd && sel[2];
    endsequence
    AST_SUPPLY_READ: assert property ( // R4
        @(posedge clk) disable iff (reset)
        s_supply_rd |=> rdata == $past(supply))
        else $error("Supply read data wrong.");

    // Phase A readback returns the held sample.
    sequence s_phase_a_rd;
        req.rd && sel[3];
    endsequence
    AST_PHASE_A_READ: assert property ( // R5
        @(posedge clk) disable iff (reset)
        s_phase_a_rd |=> rdata == $past(phase_a))
        else $error("Phase A read data wrong.");

    // Phase C readback returns the held sample.
    sequence s_phase_c_rd;
        req.rd && sel[5];
    endsequence
    AST_PHASE_C_READ: assert property ( // R7
        @(posedge clk) disable iff (reset)
        s_phase_c_rd |=> rdata == $past(phase_c))
        else $error("Phase C read data wrong.");

    // An illegal gain code from the core must leave the standing code;
    // software would otherwise see an encoding with no meaning.
    sequence s_gain_bad;
        core_load.sense_gain &&
            core_value.sense_gain > feedback_pkg::GAIN_X1;
    endsequence
    AST_GAIN_KEEP: assert property ( // R2
        @(posedge clk) disable iff (reset)
        s_gain_bad |=> $stable(sense_gain))
        else $error("Illegal gain code reached the readback.");

    // A legal gain code loads as given.
    AST_GAIN_LOAD: assert property ( // R2
        @(posedge clk) disable iff (reset)
        (core_load.sense_gain &&
            core_value.sense_gain <= feedback_pkg::GAIN_X1)
        |=> sense_gain == $past(core_value.sense_gain))
        else $error("Legal gain code not loaded.");

    // An illegal range code from the core must leave the standing code.
    sequence s_range_bad;
        core_load.volt_range &&
            core_value.volt_range > feedback_pkg::RANGE_15V;
    endsequence
    AST_RANGE_KEEP: assert property ( // R3
        @(posedge clk) disable iff (reset)
        s_range_bad |=> $stable(volt_range))
        else $error("Illegal range code reached the readback.");

    // A legal range code loads as given.
    AST_RANGE_LOAD: assert property ( // R3
        @(posedge clk) disable iff (reset)
        (core_load.volt_range &&
            core_value.volt_range <= feedback_pkg::RANGE_15V)
        |=> volt_range == $past(core_value.volt_range))
        else $error("Legal range code not loaded.");

    // The three phase samples load on one strobe, so B follows A.
    AST_PHASE_B_LOAD: assert property ( // R6
        @(posedge clk) disable iff (reset)
        s_phase_load |=> phase_b == $past(core_value.phase_b))
        else $error("Phase B sample not loaded.");

    // Phase C loads on the same strobe as well.
    AST_PHASE_C_LOAD: assert property ( // R7
        @(posedge clk) disable iff (reset)
        s_phase_load |=> phase_c == $past(core_value.phase_c))
        else $error("Phase C sample not loaded.");
endmodule

// *** testbench/host_model.sv ***
`timescale 1ns/1ps
// Host model issuing register requests and collecting the answers.
module host_model (
    input wire logic clk,
    output feedback_pkg::reg_req_t req,
    input wire logic [31:0] rdata,
    input wire logic rvalid,
    input wire logic rerr
);
    initial req = '0;

    // One request pulse; the answer is sampled once the next edge lands.
    // A released address shows its inverse so no stale value looks valid.
    task automatic xfer(input logic rd, input logic wr,
        input logic [11:0] a, input logic [31:0] w,
        output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        req <= '{rd: rd, wr: wr, addr: a, wdata: w};
        @(posedge clk);
        req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~w};
        #1;
        d = rdata;
        r = {rvalid, rerr};
    endtask
endmodule

// *** testbench/motor_feedback_readback_regs_tb.sv ***
`timescale 1ns/1ps
// Self-checking bench of the feedback register bank.
module motor_feedback_readback_regs_tb;
    logic clk;
    logic reset;
    feedback_pkg::feedback_t cv;
    feedback_pkg::feedback_t core_value;
    feedback_pkg::feedback_stb_t core_load;
    feedback_pkg::reg_req_t req;
    logic [31:0] rdata;
    logic rvalid;
    logic rerr;
    logic [31:0] d;
    logic [1:0] r;
    logic [31:0] ex [6];
    logic [11:0] offs [6] = '{feedback_pkg::OFF_SENSE_GAIN,
        feedback_pkg::OFF_VOLT_RANGE, feedback_pkg::OFF_SUPPLY,
        feedback_pkg::OFF_PHASE_A, feedback_pkg::OFF_PHASE_B,
        feedback_pkg::OFF_PHASE_C};
    int num_errors = 0;
    int total_checks = 0;

    motor_feedback_readback_regs dut_u (.clk(clk), .reset(reset),
        .core_value(core_value), .core_load(core_load), .req(req),
        .rdata(rdata), .rvalid(rvalid), .rerr(rerr));
    host_model host_u (.clk(clk), .req(req), .rdata(rdata),
        .rvalid(rvalid), .rerr(rerr));

    // The 25 MHz clock.
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic check(string n, logic [31:0] s, logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask

    // A read must answer with rvalid and no error, since all offsets map.
    task automatic rd_chk(int i, logic [31:0] e);
        host_u.xfer(1'b1, 1'b0, offs[i], 32'h0, d, r);
        check("rdata", d, e);
        check("resp", {30'h0, r}, 32'h2);
    endtask

    task automatic ld(logic [3:0] stb);
        @(posedge clk);
        core_value <= cv;
        core_load <= stb;
        @(posedge clk);
        core_load <= '0;
    endtask

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Watchdog sized well above the roughly 120 cycles of the tests.
    initial begin
        repeat (3000) @(posedge clk);
        num_errors++;
        tally_and_finish();
    end

    // Main sequence.
    initial begin
        reset = 1'b1;
        cv = '0;
        core_value = '0;
        core_load = '0;
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        for (int i = 0; i < 6; i++) rd_chk(i, 32'h0);
        for (int g = 0; g < 4; g++) begin
            cv.sense_gain = 16'(g);
            ld(4'h8);
            rd_chk(0, 32'(g));
        end
        for (int g = 0; g < 3; g++) begin
            cv.volt_range = 16'(g);
            ld(4'h4);
            rd_chk(1, 32'(g));
        end
        // Out-of-range codes leave the previous code standing.
        cv.sense_gain = 16'h0005;
        cv.volt_range = 16'h0003;
        ld(4'hc);
        cv.supply = 32'h0f00_0001;
        cv.phase_a = 32'h1234_5678;
        cv.phase_b = 32'h8765_4321;
        cv.phase_c = 32'hffff_fffe;
        ld(4'h3);
        ex = '{32'h3, 32'h2, cv.supply, cv.phase_a, cv.phase_b, cv.phase_c};
        for (int i = 0; i < 6; i++) rd_chk(i, ex[i]);
        // Writes are acknowledged yet change nothing; rereads match too.
        for (int i = 0; i < 6; i++) begin
            host_u.xfer(1'b0, 1'b1, offs[i], 32'hffff_ffff, d, r);
            check("wresp", {30'h0, r}, 32'h2);
            check("rdata hold", d, ex[5]);
        end
        for (int i = 0; i < 6; i++) rd_chk(i, ex[i]);
        for (int i = 0; i < 6; i++) rd_chk(i, ex[i]);
        // Read and write together: the read wins.
        host_u.xfer(1'b1, 1'b1, offs[2], 32'h0, d, r);
        check("rd wins", d, ex[2]);
        check("rd wins resp", {30'h0, r}, 32'h2);
        // A read taken with a phase load sees the old sample; a read one
        // cycle after the load sees the new one.
        cv.phase_b = 32'h0bad_cafe;
        fork
            ld(4'h1);
            host_u.xfer(1'b1, 1'b0, offs[4], 32'h0, d, r);
        join
        check("old phase b", d, ex[4]);
        cv.phase_b = 32'h5a5a_a5a5;
        fork
            ld(4'h1);
            begin
                @(posedge clk);
                host_u.xfer(1'b1, 1'b0, offs[4], 32'h0, d, r);
            end
        join
        check("new phase b", d, cv.phase_b);
        host_u.xfer(1'b1, 1'b0, 12'h470, 32'h0, d, r);
        check("unmapped rdata", d, 32'h0);
        check("unmapped resp", {30'h0, r}, 32'h3);
        // A second reset in mid-run clears every value again.
        @(posedge clk);
        reset <= 1'b1;
        @(posedge clk);
        reset <= 1'b0;
        for (int i = 0; i < 6; i++) rd_chk(i, 32'h0);
        tally_and_finish();
    end
endmodule
